// *** src/metcfg_pkg.sv ***
// Constants, encodings and carrier types for the metering configuration bank.
// Assumes a byte-wide configuration port driven by the on-chip application processor.
package metcfg_pkg;

  // Byte addresses of the configuration space
  localparam logic [15:0] ADDR_CE_CTRL = 16'h2106;
  localparam logic [15:0] ADDR_CE_LOC = 16'h2109;
  localparam logic [15:0] ADDR_DIFF = 16'h210C;
  localparam logic [15:0] ADDR_CONV_DIV = 16'h2200;
  localparam logic [15:0] ADDR_ID_HIGH = 16'h2300;
  localparam logic [15:0] ADDR_ID_LOW = 16'h2301;
  localparam logic [15:0] ADDR_ANALOG = 16'h2704;
  localparam logic [15:0] ADDR_REMOTE = 16'h2709;
  localparam logic [15:0] ADDR_BATT = 16'h2885;
  localparam logic [3:0] CFG_SPACE_NIBBLE = 4'h2;

  // Field positions inside their bytes
  localparam int CE_EN_BIT = 0;
  localparam int REF_CHOP_LSB = 2;
  localparam int LOC_LSB = 0;
  localparam int DIFF01_BIT = 4;
  localparam int DIFF23_BIT = 5;
  localparam int DIFF45_BIT = 6;
  localparam int CONV_DIV_BIT = 5;
  localparam int BATT_LOAD_BIT = 3;
  localparam int CONV_EN_BIT = 4;
  localparam int REMOTE_CHOP_LSB = 6;
  localparam int LOC_BASE_SHIFT = 10;

  // Chop select encodings
  typedef enum logic [1:0] {
    CHOP_AUTO_A = 2'b00,
    CHOP_POS = 2'b01,
    CHOP_NEG = 2'b10,
    CHOP_AUTO_B = 2'b11
  } metcfg_chop_e;

  // Reset values
  localparam logic [5:0] LOC_RESET = 6'h1F;
  localparam logic [2:0] DIFF_RESET = 3'h0;
  localparam logic FLAG_RESET = 1'b0;
  localparam metcfg_chop_e CHOP_SEL_RESET = CHOP_AUTO_A;
  localparam logic CHOP_STATE_RESET = 1'b1;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  // Wake values, kept apart from reset values
  localparam logic [5:0] LOC_WAKE = 6'h1F;
  localparam logic [2:0] DIFF_WAKE = 3'h0;
  localparam logic FLAG_WAKE = 1'b0;
  localparam metcfg_chop_e CHOP_SEL_WAKE = CHOP_AUTO_A;

  // Arbitrary neutral identity value
  localparam logic [15:0] PART_IDENTITY = 16'h0A5C;

  // Converter clock divider terminal counts (divide by 4 and by 8)
  localparam logic [2:0] CONV_DIV4_LAST = 3'h3;
  localparam logic [2:0] CONV_DIV8_LAST = 3'h7;

  // Master clock rates in Hz and divider shifts
  localparam logic [31:0] MCLK_SLOW_HZ = 32'h0060_0000;
  localparam logic [31:0] MCLK_FAST_HZ = 32'h012C_0000;
  localparam int DIV4_SHIFT = 2;
  localparam int DIV8_SHIFT = 3;

  // Processor access to configuration space
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } metcfg_bus_s;

  // All state of the bank except the converter clock divider counter and tick
  typedef struct packed {
    logic ce_enable;
    metcfg_chop_e ref_chop_sel;
    logic [5:0] loc;
    logic [2:0] diff;
    logic conv_div;
    logic batt_load;
    logic conv_enable;
    metcfg_chop_e remote_chop_sel;
    logic ref_chop;
    logic remote_chop;
    logic sync_prev;
    logic [7:0] batt_level;
    logic [7:0] rdata;
    logic rvalid;
    logic [31:0] rate_hz;
  } metcfg_state_s;

  // State of the converter clock divider
  typedef struct packed {
    logic [2:0] count;
    logic tick;
  } metcfg_div_s;

endpackage : metcfg_pkg

// *** src/metcfg_clkdiv.sv ***
// Converter and filter clock enable divider.
// Assumes enable and div8 come from flops of the configuration bank.
`timescale 1ns/1ps
`default_nettype none
module metcfg_clkdiv (
  input wire logic mclk, // Master clock
  input wire logic resetn, // Synchronous reset, active low
  input wire logic enable, // Converter enabled
  input wire logic div8, // 1 divides by eight, 0 by four
  output logic tick // One-cycle converter clock enable
);

  metcfg_pkg::metcfg_div_s st;
  metcfg_pkg::metcfg_div_s next_st;
  logic [2:0] last;

  assign last = div8 ? metcfg_pkg::CONV_DIV8_LAST : metcfg_pkg::CONV_DIV4_LAST;

  // Counter; wraps on or above the terminal so a ratio change never stalls it
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (!enable) begin
      next_st.count = 3'h0;
    end else if (st.count >= last) begin
      next_st.count = 3'h0;
      next_st.tick = 1'b1;
    end else begin
      next_st.count = st.count + 3'h1;
    end
    if (!resetn) begin
      next_st.count = 3'h0;
      next_st.tick = 1'b0;
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    st <= next_st;
  end

  assign tick = st.tick;

  sequence s_steady_div4;
    (enable && !div8) [*8];
  endsequence

  property p_div4_period;
    @(posedge mclk) disable iff (!resetn)
      s_steady_div4 ##0 tick |-> $past(tick, 4) && !$past(tick, 1) && !$past(tick, 2)
        && !$past(tick, 3);
  endproperty
  a_div4_period: assert property (p_div4_period) else $error("divide by four period wrong");

  property p_div_off;
    @(posedge mclk) disable iff (!resetn)
      !enable |=> !tick;
  endproperty
  a_div_off: assert property (p_div_off) else $error("tick while converter disabled");

endmodule : metcfg_clkdiv
`default_nettype wire

// *** src/metcfg_bank.sv ***
// Metering configuration and status bank: converter, compute engine, chop and pairing bits.
// Assumes the application processor gives one-cycle rd/wr strobes synchronous to mclk,
// and that mux_frame_sync, accum_end and the battery sample are synchronous to mclk.
`timescale 1ns/1ps
`default_nettype none
module metcfg_bank (
  input wire logic mclk, // System clock
  input wire logic resetn, // Synchronous reset, active low
  input wire logic wake, // One-cycle wake event
  input wire metcfg_pkg::metcfg_bus_s bus, // Processor configuration access
  output logic [7:0] rdata, // Read data, one cycle after rd
  output logic rvalid, // Read data valid pulse
  input wire logic pll_fast, // Fast master clock selected
  input wire logic mux_frame_sync, // Internal mux frame sync
  input wire logic accum_end, // Current sync edge ends an accumulation
  input wire logic [7:0] battery_sample, // Battery measurement from the monitor
  input wire logic battery_sample_valid, // New battery measurement strobe
  output logic converter_enable, // Converter powered
  output logic reference_enable, // Voltage reference powered
  output logic converter_clk_en, // Converter and filter clock enable pulse
  output logic [31:0] converter_rate_hz, // Resulting converter clock rate
  output logic battery_load_enable, // Test load on backup battery
  output logic compute_engine_enable, // Compute engine running
  output logic [15:0] program_base, // Compute engine program start address
  output logic reference_chop, // Bandgap chop state, 1 is positive
  output logic remote_chop, // Remote sensor chop state, 1 is positive
  output logic [2:0] diff_enable // Pairs 4/5, 2/3, 0/1 differential
);

  metcfg_pkg::metcfg_state_s st;
  metcfg_pkg::metcfg_state_s next_st;
  logic sync_rise;
  logic [7:0] rd_byte;

  // Address lies in the configuration window
  function automatic logic in_cfg_space(input logic [15:0] addr);
    return addr[15:12] == metcfg_pkg::CFG_SPACE_NIBBLE;
  endfunction : in_cfg_space

  // Write strobe aimed at one configuration byte
  function automatic logic write_hit(input metcfg_pkg::metcfg_bus_s b, input logic [15:0] addr);
    return b.wr && in_cfg_space(b.addr) && (b.addr == addr);
  endfunction : write_hit

  // Next chop state for a select; auto modes alternate unless suppressed
  function automatic logic chop_next(input metcfg_pkg::metcfg_chop_e sel, input logic cur,
                                     input logic hold);
    logic res;
    res = cur;
    unique case (sel)
      metcfg_pkg::CHOP_POS: res = 1'b1;
      metcfg_pkg::CHOP_NEG: res = 1'b0;
      metcfg_pkg::CHOP_AUTO_A, metcfg_pkg::CHOP_AUTO_B: res = hold ? cur : !cur;
    endcase
    return res;
  endfunction : chop_next

  assign sync_rise = mux_frame_sync && !st.sync_prev;

  // Read mux; reserved and out-of-window addresses return zero
  always_comb begin
    rd_byte = 8'h00;
    if (in_cfg_space(bus.addr)) begin
      unique case (bus.addr)
        metcfg_pkg::ADDR_CE_CTRL: begin
          rd_byte[metcfg_pkg::CE_EN_BIT] = st.ce_enable;
          rd_byte[metcfg_pkg::REF_CHOP_LSB +: 2] = st.ref_chop_sel;
        end
        metcfg_pkg::ADDR_CE_LOC: rd_byte[metcfg_pkg::LOC_LSB +: 6] = st.loc;
        metcfg_pkg::ADDR_DIFF: begin
          rd_byte[metcfg_pkg::DIFF01_BIT] = st.diff[0];
          rd_byte[metcfg_pkg::DIFF23_BIT] = st.diff[1];
          rd_byte[metcfg_pkg::DIFF45_BIT] = st.diff[2];
        end
        metcfg_pkg::ADDR_CONV_DIV: rd_byte[metcfg_pkg::CONV_DIV_BIT] = st.conv_div;
        metcfg_pkg::ADDR_ID_HIGH: rd_byte = metcfg_pkg::PART_IDENTITY[15:8];
        metcfg_pkg::ADDR_ID_LOW: rd_byte = metcfg_pkg::PART_IDENTITY[7:0];
        metcfg_pkg::ADDR_ANALOG: begin
          rd_byte[metcfg_pkg::BATT_LOAD_BIT] = st.batt_load;
          rd_byte[metcfg_pkg::CONV_EN_BIT] = st.conv_enable;
        end
        metcfg_pkg::ADDR_REMOTE: rd_byte[metcfg_pkg::REMOTE_CHOP_LSB +: 2] = st.remote_chop_sel;
        metcfg_pkg::ADDR_BATT: rd_byte = st.batt_level;
        default: rd_byte = 8'h00;
      endcase
    end
  end

  // Next state: writes, chop sequencing, reads, then wake and reset override
  always_comb begin
    next_st = st;
    next_st.rvalid = 1'b0;
    next_st.sync_prev = mux_frame_sync;
    if (battery_sample_valid) begin
      next_st.batt_level = battery_sample;
    end
    // fields change on a write here; wake and reset override them below
    if (write_hit(bus, metcfg_pkg::ADDR_CE_CTRL)) begin
      next_st.ce_enable = bus.wdata[metcfg_pkg::CE_EN_BIT];
      next_st.ref_chop_sel = metcfg_pkg::metcfg_chop_e'(bus.wdata[metcfg_pkg::REF_CHOP_LSB +: 2]);
    end
    if (write_hit(bus, metcfg_pkg::ADDR_CE_LOC)) begin
      next_st.loc = bus.wdata[metcfg_pkg::LOC_LSB +: 6];
    end
    if (write_hit(bus, metcfg_pkg::ADDR_DIFF)) begin
      next_st.diff = {bus.wdata[metcfg_pkg::DIFF45_BIT], bus.wdata[metcfg_pkg::DIFF23_BIT],
                      bus.wdata[metcfg_pkg::DIFF01_BIT]};
    end
    if (write_hit(bus, metcfg_pkg::ADDR_CONV_DIV)) begin
      next_st.conv_div = bus.wdata[metcfg_pkg::CONV_DIV_BIT];
    end
    if (write_hit(bus, metcfg_pkg::ADDR_ANALOG)) begin
      next_st.batt_load = bus.wdata[metcfg_pkg::BATT_LOAD_BIT];
      next_st.conv_enable = bus.wdata[metcfg_pkg::CONV_EN_BIT];
    end
    if (write_hit(bus, metcfg_pkg::ADDR_REMOTE)) begin
      next_st.remote_chop_sel =
        metcfg_pkg::metcfg_chop_e'(bus.wdata[metcfg_pkg::REMOTE_CHOP_LSB +: 2]);
    end
    // chop on sync edge; reference skips at accumulation end, remote does not
    if (sync_rise) begin
      next_st.ref_chop = chop_next(st.ref_chop_sel, st.ref_chop, accum_end);
      next_st.remote_chop = chop_next(st.remote_chop_sel, st.remote_chop, 1'b0);
    end
    // Reads return state before any same-cycle write
    if (bus.rd) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = rd_byte;
    end
    next_st.rate_hz = (pll_fast ? metcfg_pkg::MCLK_FAST_HZ : metcfg_pkg::MCLK_SLOW_HZ)
                      >> (st.conv_div ? metcfg_pkg::DIV8_SHIFT : metcfg_pkg::DIV4_SHIFT);
    // wake reload beats a same-cycle write
    if (wake) begin
      next_st.ce_enable = metcfg_pkg::FLAG_WAKE;
      next_st.ref_chop_sel = metcfg_pkg::CHOP_SEL_WAKE;
      next_st.loc = metcfg_pkg::LOC_WAKE;
      next_st.diff = metcfg_pkg::DIFF_WAKE;
      next_st.conv_div = metcfg_pkg::FLAG_WAKE;
      next_st.batt_load = metcfg_pkg::FLAG_WAKE;
      next_st.conv_enable = metcfg_pkg::FLAG_WAKE;
      next_st.remote_chop_sel = metcfg_pkg::CHOP_SEL_WAKE;
    end
    if (!resetn) begin
      next_st.ce_enable = metcfg_pkg::FLAG_RESET;
      next_st.ref_chop_sel = metcfg_pkg::CHOP_SEL_RESET;
      next_st.loc = metcfg_pkg::LOC_RESET;
      next_st.diff = metcfg_pkg::DIFF_RESET;
      next_st.conv_div = metcfg_pkg::FLAG_RESET;
      next_st.batt_load = metcfg_pkg::FLAG_RESET;
      next_st.conv_enable = metcfg_pkg::FLAG_RESET;
      next_st.remote_chop_sel = metcfg_pkg::CHOP_SEL_RESET;
      next_st.ref_chop = metcfg_pkg::CHOP_STATE_RESET;
      next_st.remote_chop = metcfg_pkg::CHOP_STATE_RESET;
      next_st.sync_prev = 1'b0;
      next_st.batt_level = metcfg_pkg::BYTE_RESET;
      next_st.rdata = metcfg_pkg::BYTE_RESET;
      next_st.rvalid = 1'b0;
      next_st.rate_hz = metcfg_pkg::MCLK_SLOW_HZ >> metcfg_pkg::DIV4_SHIFT;
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    st <= next_st;
  end

  metcfg_clkdiv u_clkdiv (
    .mclk(mclk),
    .resetn(resetn),
    .enable(st.conv_enable),
    .div8(st.conv_div),
    .tick(converter_clk_en)
  );

  // Outputs straight from state; converter and reference share one enable
  assign rdata = st.rdata;
  assign rvalid = st.rvalid;
  assign converter_enable = st.conv_enable;
  assign reference_enable = st.conv_enable;
  assign converter_rate_hz = st.rate_hz;
  assign battery_load_enable = st.batt_load;
  assign compute_engine_enable = st.ce_enable;
  assign program_base = {st.loc, 10'h000};
  assign reference_chop = st.ref_chop;
  assign remote_chop = st.remote_chop;
  assign diff_enable = st.diff;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence s_loc_write;
    write_hit(bus, metcfg_pkg::ADDR_CE_LOC) && !wake;
  endsequence

  sequence s_ref_toggle_edge;
    sync_rise && st.ref_chop_sel[0] == st.ref_chop_sel[1];
  endsequence

  property p_reset_values;
    $rose(resetn) |-> program_base == 16'h7C00 && !compute_engine_enable && !converter_enable
      && diff_enable == 3'h0 && !battery_load_enable;
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("reset values wrong");

  property p_wake_values;
    wake |=> program_base == 16'h7C00 && !compute_engine_enable && !converter_enable
      && !reference_enable && diff_enable == 3'h0;
  endproperty
  a_wake_values: assert property (p_wake_values) else $error("wake values wrong");

  property p_loc_base;
    s_loc_write |=> program_base == {$past(bus.wdata[5:0]), 10'h000};
  endproperty
  a_loc_base: assert property (p_loc_base) else $error("program base not location times 1024");

  property p_loc_hold;
    !write_hit(bus, metcfg_pkg::ADDR_CE_LOC) && !wake |=> $stable(program_base);
  endproperty
  a_loc_hold: assert property (p_loc_hold) else $error("location changed without write");

  property p_ref_toggle;
    s_ref_toggle_edge ##0 !accum_end |=> reference_chop != $past(reference_chop);
  endproperty
  a_ref_toggle: assert property (p_ref_toggle) else $error("reference chop did not toggle");

  property p_ref_skip;
    s_ref_toggle_edge ##0 accum_end |=> $stable(reference_chop);
  endproperty
  a_ref_skip: assert property (p_ref_skip) else $error("reference chop toggled at interval end");

  property p_ref_fixed;
    sync_rise && st.ref_chop_sel == metcfg_pkg::CHOP_NEG |=> !reference_chop ##1
      (sync_rise || !reference_chop);
  endproperty
  a_ref_fixed: assert property (p_ref_fixed) else $error("reference chop not held reversed");

  property p_ref_no_edge;
    !sync_rise |=> $stable(reference_chop) && $stable(remote_chop);
  endproperty
  a_ref_no_edge: assert property (p_ref_no_edge) else $error("chop moved without sync edge");

  property p_remote_chop;
    sync_rise && st.remote_chop_sel == metcfg_pkg::CHOP_POS |=> remote_chop;
  endproperty
  a_remote_chop: assert property (p_remote_chop) else $error("remote chop not positive");

  property p_identity;
    bus.rd && bus.addr == metcfg_pkg::ADDR_ID_LOW |=> rvalid && rdata == 8'h5C;
  endproperty
  a_identity: assert property (p_identity) else $error("identity low byte wrong");

  property p_outside;
    bus.rd && bus.addr[15:12] != 4'h2 |=> rvalid && rdata == 8'h00;
  endproperty
  a_outside: assert property (p_outside) else $error("read outside window not zero");

  property p_battery;
    battery_sample_valid ##1 (bus.rd && bus.addr == metcfg_pkg::ADDR_BATT && !battery_sample_valid)
      |=> rdata == $past(battery_sample, 2);
  endproperty
  a_battery: assert property (p_battery) else $error("battery result not returned");

  property p_diff;
    write_hit(bus, metcfg_pkg::ADDR_DIFF) && !wake |=>
      diff_enable == {$past(bus.wdata[6]), $past(bus.wdata[5]), $past(bus.wdata[4])};
  endproperty
  a_diff: assert property (p_diff) else $error("pairing enables wrong");

  property p_analog;
    write_hit(bus, metcfg_pkg::ADDR_ANALOG) && !wake |=> battery_load_enable == $past(bus.wdata[3])
      && converter_enable == $past(bus.wdata[4]) && reference_enable == converter_enable;
  endproperty
  a_analog: assert property (p_analog) else $error("analog enables wrong");

  property p_ce_enable;
    write_hit(bus, metcfg_pkg::ADDR_CE_CTRL) && !wake |=> compute_engine_enable == $past(bus.wdata[0]);
  endproperty
  a_ce_enable: assert property (p_ce_enable) else $error("compute enable wrong");

  property p_rate;
    pll_fast && st.conv_div |=> converter_rate_hz == 32'h0025_8000;
  endproperty
  a_rate: assert property (p_rate) else $error("converter rate wrong");

endmodule : metcfg_bank
`default_nettype wire

// *** testbench/tb.sv ***
// Self-checking bench for the metering configuration bank.
// Assumes the bank answers reads one cycle after rd and registers writes at the taking edge.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic mclk = 0, resetn = 0, wake = 0, pll_fast = 0;
  logic mux_frame_sync = 0, accum_end = 0, battery_sample_valid = 0;
  logic [7:0] battery_sample = 8'h00, rdata;
  metcfg_pkg::metcfg_bus_s bus = '0;
  logic rvalid, converter_enable, reference_enable, converter_clk_en, battery_load_enable;
  logic compute_engine_enable, reference_chop, remote_chop;
  logic [31:0] converter_rate_hz;
  logic [15:0] program_base;
  logic [2:0] diff_enable;
  int bad_count = 0, n_compared = 0, cycles = 0;

  metcfg_bank dut (.mclk(mclk), .resetn(resetn), .wake(wake), .bus(bus), .rdata(rdata),
    .rvalid(rvalid), .pll_fast(pll_fast), .mux_frame_sync(mux_frame_sync),
    .accum_end(accum_end), .battery_sample(battery_sample),
    .battery_sample_valid(battery_sample_valid), .converter_enable(converter_enable),
    .reference_enable(reference_enable), .converter_clk_en(converter_clk_en),
    .converter_rate_hz(converter_rate_hz), .battery_load_enable(battery_load_enable),
    .compute_engine_enable(compute_engine_enable), .program_base(program_base),
    .reference_chop(reference_chop), .remote_chop(remote_chop), .diff_enable(diff_enable));

  // 40 MHz clock
  always #12.5 mclk = ~mclk;

  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count = bad_count + 1;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run

  // Inputs move 2 ns after each rising edge
  task automatic step(input int n);
    repeat (n) begin
      @(posedge mclk);
      #2;
    end
  endtask : step

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Strobes are left up so back-to-back accesses never assign a strobe twice in one step
  task automatic wr_byte(input logic [15:0] a, input logic [7:0] d);
    bus.addr = a;
    bus.wdata = d;
    bus.rd = 1'b0;
    bus.wr = 1'b1;
    step(1);
  endtask : wr_byte

  task automatic rd_check(input logic [15:0] a, input logic [7:0] exp);
    bus.addr = a;
    bus.wr = 1'b0;
    bus.rd = 1'b1;
    step(1);
    check("rvalid", rvalid, 1);
    check("rdata", rdata, exp);
  endtask : rd_check

  task automatic idle();
    bus.wr = 1'b0;
    bus.rd = 1'b0;
    step(1);
  endtask : idle

  task automatic pulse_sync(input logic ae);
    mux_frame_sync = 1'b1;
    accum_end = ae;
    step(1);
    mux_frame_sync = 1'b0;
    accum_end = 1'b0;
    step(1);
  endtask : pulse_sync

  // Cycles between two clock enable pulses, bounded
  task automatic gap(output int g);
    int i;
    g = 0;
    for (i = 0; i < 20 && converter_clk_en !== 1'b1; i++) step(1);
    step(1);
    for (g = 1; g < 20 && converter_clk_en !== 1'b1; g++) step(1);
  endtask : gap

  task automatic t_reset();
    check("ce", compute_engine_enable, 0);
    check("conv", converter_enable, 0);
    check("load", battery_load_enable, 0);
    check("base", program_base, 16'h7C00);
    check("diff", diff_enable, 0);
    check("rate", converter_rate_hz, 32'h0018_0000);
    rd_check(16'h2109, 8'h1F);
    rd_check(16'h2709, 8'h00);
    idle();
    $display("test reset done");
  endtask : t_reset

  task automatic t_fields();
    wr_byte(16'h2106, 8'h01);
    wr_byte(16'h2109, 8'h05);
    wr_byte(16'h210C, 8'h90);
    idle();
    check("ce", compute_engine_enable, 1);
    check("base", program_base, 16'h1400);
    check("diff", diff_enable, 3'b001);
    wr_byte(16'h210C, 8'h60);
    wr_byte(16'h2109, 8'hFF);
    idle();
    check("diff", diff_enable, 3'b110);
    check("base", program_base, 16'hFC00);
    step(10);
    check("ce hold", compute_engine_enable, 1);
    rd_check(16'h2109, 8'h3F);
    rd_check(16'h210C, 8'h60);
    rd_check(16'h2106, 8'h01);
    idle();
    $display("test fields done");
  endtask : t_fields

  task automatic t_decode();
    wr_byte(16'h3109, 8'h05);
    wr_byte(16'h0106, 8'h00);
    idle();
    check("base", program_base, 16'hFC00);
    check("ce", compute_engine_enable, 1);
    rd_check(16'h3300, 8'h00);
    rd_check(16'h2107, 8'h00);
    wr_byte(16'h2300, 8'hFF);
    rd_check(16'h2300, metcfg_pkg::PART_IDENTITY[15:8]);
    rd_check(16'h2301, metcfg_pkg::PART_IDENTITY[7:0]);
    idle();
    $display("test decode done");
  endtask : t_decode

  task automatic t_convert();
    int g;
    wr_byte(16'h2704, 8'h18);
    idle();
    check("conv", converter_enable, 1);
    check("vref", reference_enable, 1);
    check("load", battery_load_enable, 1);
    gap(g);
    check("div4", g, 4);
    wr_byte(16'h2200, 8'h20);
    idle();
    gap(g);
    gap(g);
    check("div8", g, 8);
    check("slow8", converter_rate_hz, 32'h000C_0000);
    pll_fast = 1'b1;
    step(2);
    check("fast8", converter_rate_hz, 32'h0025_8000);
    wr_byte(16'h2200, 8'h00);
    wr_byte(16'h2704, 8'h00);
    idle();
    step(1);
    check("fast4", converter_rate_hz, 32'h004B_0000);
    check("load", battery_load_enable, 0);
    gap(g);
    check("no tick", g, 20);
    pll_fast = 1'b0;
    $display("test converter done");
  endtask : t_convert

  task automatic t_battery();
    battery_sample = 8'hA7;
    battery_sample_valid = 1'b1;
    step(1);
    battery_sample_valid = 1'b0;
    battery_sample = 8'h3C;
    rd_check(16'h2885, 8'hA7);
    wr_byte(16'h2885, 8'h00);
    rd_check(16'h2885, 8'hA7);
    idle();
    $display("test battery done");
  endtask : t_battery

  task automatic t_chop();
    logic r, m;
    int s;
    // No sync edge has come since reset, so both chop states start positive
    r = metcfg_pkg::CHOP_STATE_RESET;
    m = metcfg_pkg::CHOP_STATE_RESET;
    for (s = 0; s < 4; s++) begin
      wr_byte(16'h2106, 8'(s << 2));
      wr_byte(16'h2709, 8'(s << 6));
      idle();
      pulse_sync(1'b0);
      r = (s == 1) ? 1'b1 : (s == 2) ? 1'b0 : ~r;
      m = (s == 1) ? 1'b1 : (s == 2) ? 1'b0 : ~m;
      check("ref", reference_chop, r);
      check("remote", remote_chop, m);
      pulse_sync(1'b1);
      // Remote chop still moves at the interval end; only the reference skips
      m = (s == 1) ? 1'b1 : (s == 2) ? 1'b0 : ~m;
      check("ref end", reference_chop, r);
      check("remote end", remote_chop, m);
      mux_frame_sync = 1'b1;
      step(4);
      mux_frame_sync = 1'b0;
      step(1);
      r = (s == 1) ? 1'b1 : (s == 2) ? 1'b0 : ~r;
      m = (s == 1) ? 1'b1 : (s == 2) ? 1'b0 : ~m;
      step(3);
      check("one edge", reference_chop, r);
      check("remote one edge", remote_chop, m);
    end
    $display("test chop done");
  endtask : t_chop

  task automatic t_wake();
    wr_byte(16'h2106, 8'h05);
    wr_byte(16'h210C, 8'h70);
    wr_byte(16'h2704, 8'h18);
    wr_byte(16'h2709, 8'h80);
    wr_byte(16'h2109, 8'h05);
    wake = 1'b1;
    step(1);
    wake = 1'b0;
    idle();
    check("base", program_base, 16'h7C00);
    check("ce", compute_engine_enable, 0);
    check("conv", converter_enable, 0);
    check("load", battery_load_enable, 0);
    check("diff", diff_enable, 0);
    rd_check(16'h2106, 8'h00);
    rd_check(16'h2709, 8'h00);
    idle();
    step(3);
    // Chop states left by the chop test: remote positive, reference reversed
    check("remote kept", remote_chop, 1);
    check("ref kept", reference_chop, 0);
    $display("test wake done");
  endtask : t_wake

  // Reset in mid-run must reload every field written just before it
  task automatic t_midrun_reset();
    wr_byte(16'h2109, 8'h05);
    wr_byte(16'h210C, 8'h70);
    wr_byte(16'h2704, 8'h18);
    wr_byte(16'h2200, 8'h20);
    idle();
    resetn = 1'b0;
    step(3);
    resetn = 1'b1;
    check("ref reset", reference_chop, 1);
    check("remote reset", remote_chop, 1);
    t_reset();
    $display("test mid-run reset done");
  endtask : t_midrun_reset

  initial begin
    repeat (5) @(posedge mclk);
    #2;
    resetn = 1'b1;
    t_reset();
    t_fields();
    t_decode();
    t_convert();
    t_battery();
    t_chop();
    t_wake();
    t_midrun_reset();
    complete_run();
  end
endmodule : tb
`default_nettype wire
